// file: verilog/jack_pkg.sv
`default_nettype none
package jack_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ctrl_addr     = 8'h00;
  localparam logic [7:0] switch_addr   = 8'h04;
  localparam logic [7:0] status_addr   = 8'h08;
  localparam logic [7:0] irq_stat_addr = 8'h0c;
  localparam logic [7:0] irq_mask_addr = 8'h10;

  // ==========================================================
  // control fields
  localparam int mode_lsb      = 0;
  localparam int tip_ainv_bit  = 2;
  localparam int tip_sinv_bit  = 3;
  localparam int ring_inv_bit  = 4;
  localparam int pu_high_bit   = 5;
  localparam int pu_trim_bit   = 6;
  localparam int start_bit     = 7;
  localparam int imp_trim_lsb  = 8;
  localparam int imp_trim_w    = 4;

  // ==========================================================
  // status fields
  localparam int stat_type_lsb = 8;
  localparam int stat_tip_bit  = 11;
  localparam int stat_ring_bit = 12;
  localparam int stat_cfg_bit  = 13;
  localparam int stat_imp_bit  = 14;

  // ==========================================================
  // interrupt bits
  localparam int irq_w         = 3;
  localparam int irq_tip_bit   = 0;
  localparam int irq_ring_bit  = 1;
  localparam int irq_det_bit   = 2;

  // ==========================================================
  // reset values and counts
  localparam logic [31:0] ctrl_reset   = 32'h0000_0000;
  localparam logic [7:0]  switch_reset = 8'h00;
  localparam int          dbnc_default = 16;
  localparam int          settle_default = 8;

  // ring pull-up choice codes
  localparam logic [1:0] pu_16k2  = 2'h0;
  localparam logic [1:0] pu_2m25  = 2'h1;
  localparam logic [1:0] pu_1m125 = 2'h2;

  typedef struct packed {
    logic ref_three;
    logic ref_four;
    logic filt_three;
    logic filt_four;
    logic bias_three;
    logic bias_four;
    logic gnd_three;
    logic gnd_four;
  } switch_set_s;

  typedef enum logic [2:0] {
    det_idle   = 3'b001,
    det_settle = 3'b010,
    det_apply  = 3'b100
  } det_state_e;

endpackage : jack_pkg
`default_nettype wire

// file: verilog/headset_type_and_plug_sense.sv
`timescale 1ns/1ps
`default_nettype none
module headset_type_and_plug_sense #(
  parameter int DBNC_CYCLES   = jack_pkg::dbnc_default,
  parameter int SETTLE_CYCLES = jack_pkg::settle_default
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 standby_reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 tip_sense_pin,
  input  wire logic                 ring_sense_pin,
  input  wire logic                 cmp_three_pin,
  input  wire logic                 cmp_four_pin,
  input  wire logic                 ring_imp_pin,
  output jack_pkg::switch_set_s     switch_state,
  output logic                      tip_analog_invert,
  output logic [1:0]                ring_pullup_sel,
  output logic [3:0]                impedance_threshold_trim,
  output logic                      mic_short_enable,
  output logic                      irq
);

  // ==========================================================
  // decode helpers
  function automatic logic [2:0] decode_type(input logic c3, input logic c4);
    logic [2:0] t;
    t = 3'h4;
    if (c3 && !c4) begin
      t = 3'h1;
    end else if (!c3 && c4) begin
      t = 3'h2;
    end else if (!c3 && !c4) begin
      t = 3'h3;
    end
    return t;
  endfunction : decode_type

  function automatic jack_pkg::switch_set_s type_pattern(input logic [2:0] t);
    jack_pkg::switch_set_s p;
    p = 8'ha6;
    case (t)
      3'h2:    p = 8'h59;
      3'h3:    p = 8'hf3;
      default: p = 8'ha6;
    endcase
    return p;
  endfunction : type_pattern

  // ==========================================================
  // pin synchronisers
  localparam int npin = 5;
  // sense pins idle high on their pull-ups; no false plug edge after reset
  localparam logic [npin-1:0] pin_idle = 5'h03;
  logic [npin-1:0] pin_raw;
  logic [npin-1:0] pin_meta_reg;
  logic [npin-1:0] pin_sync_reg;

  assign pin_raw = {ring_imp_pin, cmp_four_pin, cmp_three_pin,
                    ring_sense_pin, tip_sense_pin};

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_reg <= pin_idle;
      pin_sync_reg <= pin_idle;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================================
  // control registers
  logic [31:0]     ctrl_reg;
  logic [7:0]      switch_bits_reg;
  logic [2:0]      irq_stat_reg;
  logic [2:0]      irq_mask_reg;
  logic            start_pulse;
  logic            wr_take;
  logic            rd_first;
  logic [1:0]      mode;
  logic            auto_mode;

  assign wr_take   = psel && penable && pready && pwrite;
  assign rd_first  = psel && penable && !pready;
  assign mode      = ctrl_reg[jack_pkg::mode_lsb +: 2];
  assign auto_mode = mode[1];
  assign start_pulse = wr_take && (paddr == jack_pkg::ctrl_addr)
                       && pwdata[jack_pkg::start_bit];

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= jack_pkg::ctrl_reset;
    end else if (wr_take && paddr == jack_pkg::ctrl_addr) begin
      ctrl_reg <= {20'h00000, pwdata[11:8], 1'b0, pwdata[6:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      switch_bits_reg <= jack_pkg::switch_reset;
    end else if (wr_take && paddr == jack_pkg::switch_addr) begin
      switch_bits_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_take && paddr == jack_pkg::irq_mask_addr) begin
      irq_mask_reg <= pwdata[jack_pkg::irq_w-1:0];
    end
  end

  // ==========================================================
  // automatic type detection
  jack_pkg::det_state_e det_state_reg;
  logic [15:0]          settle_cnt_reg;
  logic [2:0]           type_reg;
  logic                 det_done;

  assign det_done = (det_state_reg == jack_pkg::det_apply);

  always_ff @(posedge mclk) begin
    if (reset) begin
      det_state_reg  <= jack_pkg::det_idle;
      settle_cnt_reg <= 16'h0000;
      type_reg       <= 3'h0;
    end else begin
      case (det_state_reg)
        jack_pkg::det_idle: begin
          settle_cnt_reg <= 16'h0000;
          if (start_pulse && pwdata[jack_pkg::mode_lsb + 1]) begin
            det_state_reg <= jack_pkg::det_settle;
          end
        end
        jack_pkg::det_settle: begin
          settle_cnt_reg <= settle_cnt_reg + 16'h0001;
          if (!auto_mode) begin
            det_state_reg <= jack_pkg::det_idle;
          end else if (settle_cnt_reg == 16'(SETTLE_CYCLES - 1)) begin
            type_reg      <= decode_type(pin_sync_reg[2], pin_sync_reg[3]);
            det_state_reg <= jack_pkg::det_apply;
          end
        end
        jack_pkg::det_apply: begin
          det_state_reg <= jack_pkg::det_idle;
        end
        default: begin
          det_state_reg <= jack_pkg::det_idle;
        end
      endcase
    end
  end

  // ==========================================================
  // standby domain switch hold
  jack_pkg::switch_set_s switch_state_reg;
  logic                  configured_reg;
  logic                  manual_load;

  assign manual_load = !auto_mode && wr_take && paddr == jack_pkg::switch_addr;

  // cleared only by the standby reset so core resets keep the jack set up
  always_ff @(posedge mclk) begin
    if (standby_reset) begin
      switch_state_reg <= 8'h00;
      configured_reg   <= 1'b0;
    end else if (manual_load) begin
      switch_state_reg <= pwdata[7:0];
      configured_reg   <= 1'b1;
    end else if (det_done && auto_mode) begin
      switch_state_reg <= type_pattern(type_reg);
      configured_reg   <= 1'b1;
    end
  end

  assign switch_state     = switch_state_reg;
  assign mic_short_enable = configured_reg;

  // ==========================================================
  // sense interpretation and debounce
  logic [1:0]  sense_det;
  logic [1:0]  present_reg;
  logic [15:0] dbnc_cnt_reg [2];

  // low means inserted unless the wiring is inverted
  assign sense_det[0] = pin_sync_reg[0] ^ !ctrl_reg[jack_pkg::tip_ainv_bit];
  assign sense_det[1] = pin_sync_reg[1] ^ !ctrl_reg[jack_pkg::ring_inv_bit];

  generate
    for (genvar i = 0; i < 2; i++) begin : g_dbnc
      always_ff @(posedge mclk) begin
        if (reset) begin
          dbnc_cnt_reg[i] <= 16'h0000;
          present_reg[i]  <= 1'b0;
        end else if (sense_det[i] == present_reg[i]) begin
          dbnc_cnt_reg[i] <= 16'h0000;
        end else if (dbnc_cnt_reg[i] == 16'(DBNC_CYCLES - 1)) begin
          dbnc_cnt_reg[i] <= 16'h0000;
          present_reg[i]  <= sense_det[i];
        end else begin
          dbnc_cnt_reg[i] <= dbnc_cnt_reg[i] + 16'h0001;
        end
      end
    end
  endgenerate

  logic [1:0] present_dly_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      present_dly_reg <= 2'h0;
    end else begin
      present_dly_reg <= present_reg;
    end
  end

  // ==========================================================
  // interrupts
  logic [2:0] irq_event;
  logic [2:0] irq_clear;

  assign irq_event = {det_done, present_reg ^ present_dly_reg};
  assign irq_clear = (wr_take && paddr == jack_pkg::irq_stat_addr)
                     ? pwdata[2:0] : 3'h0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
    end
  end

  assign irq = |(irq_stat_reg & ~irq_mask_reg);

  // ==========================================================
  // analog controls
  always_comb begin
    if (!ctrl_reg[jack_pkg::pu_high_bit]) begin
      ring_pullup_sel = jack_pkg::pu_16k2;
    end else if (ctrl_reg[jack_pkg::pu_trim_bit]) begin
      ring_pullup_sel = jack_pkg::pu_1m125;
    end else begin
      ring_pullup_sel = jack_pkg::pu_2m25;
    end
  end

  assign impedance_threshold_trim =
    ctrl_reg[jack_pkg::imp_trim_lsb +: jack_pkg::imp_trim_w];
  assign tip_analog_invert = ctrl_reg[jack_pkg::tip_ainv_bit];

  // ==========================================================
  // status word
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[7:0] = switch_state_reg;
    status_word[jack_pkg::stat_type_lsb +: 3] = type_reg;
    // status invert touches only the reported tip bit
    status_word[jack_pkg::stat_tip_bit] =
      present_reg[0] ^ ctrl_reg[jack_pkg::tip_sinv_bit];
    status_word[jack_pkg::stat_ring_bit] = present_reg[1];
    status_word[jack_pkg::stat_cfg_bit]  = configured_reg;
    status_word[jack_pkg::stat_imp_bit]  = pin_sync_reg[4];
  end

  // ==========================================================
  // apb slave: one wait state, read data from a flop
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        addr_ok;

  assign addr_ok = (paddr == jack_pkg::ctrl_addr) ||
                   (paddr == jack_pkg::switch_addr) ||
                   (paddr == jack_pkg::status_addr) ||
                   (paddr == jack_pkg::irq_stat_addr) ||
                   (paddr == jack_pkg::irq_mask_addr);

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= rd_first;
      pslverr_reg <= rd_first && !addr_ok;
      if (rd_first) begin
        case (paddr)
          jack_pkg::ctrl_addr:     prdata_reg <= ctrl_reg;
          jack_pkg::switch_addr:   prdata_reg <= {24'h000000, switch_bits_reg};
          jack_pkg::status_addr:   prdata_reg <= status_word;
          jack_pkg::irq_stat_addr: prdata_reg <= {29'h0000000, irq_stat_reg};
          jack_pkg::irq_mask_addr: prdata_reg <= {29'h0000000, irq_mask_reg};
          default:                 prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

endmodule : headset_type_and_plug_sense
`default_nettype wire

// file: sim/plug_model.sv
`timescale 1ns/1ps
`default_nettype none
module plug_model (
  input  wire logic       plugged,
  input  wire logic       metal,
  input  wire logic       tip_inv,
  input  wire logic       ring_inv,
  input  wire logic [2:0] htype,
  output logic            tip_pin,
  output logic            ring_pin,
  output logic            c3,
  output logic            c4
);
  // ==========================================================
  // sense contacts float high unless shorted by the plug; tip_inv and ring_inv drive them high when plugged instead
  assign tip_pin  = tip_inv ? plugged : !plugged;
  assign ring_pin = ring_inv ? plugged : !(plugged && metal);
  assign c3       = htype == 3'h1 || htype == 3'h4;
  assign c4       = htype == 3'h2 || htype == 3'h4;
endmodule : plug_model
`default_nettype wire

// file: sim/jack_props.sv
`timescale 1ns/1ps
`default_nettype none
module jack_props (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  standby_reset,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire jack_pkg::switch_set_s switch_state,
  input wire logic                  tip_analog_invert,
  input wire logic [1:0]            ring_pullup_sel,
  input wire logic [3:0]            impedance_threshold_trim,
  input wire logic                  mic_short_enable
);
  logic wr, ctl_wr, sw_wr, cfg_seen, auto_reg;
  assign wr     = psel && penable && pready && pwrite;
  assign ctl_wr = wr && paddr == jack_pkg::ctrl_addr;
  assign sw_wr  = wr && paddr == jack_pkg::switch_addr;
  // ==========================================================
  // configuration can only follow a switch write or a detect start
  always_ff @(posedge mclk) begin
    if (standby_reset) begin
      cfg_seen <= 1'b0;
    end else if (sw_wr || (ctl_wr && pwdata[jack_pkg::start_bit])) begin
      cfg_seen <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      auto_reg <= 1'b0;
    end else if (ctl_wr) begin
      auto_reg <= pwdata[jack_pkg::mode_lsb + 1];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_ANSWER: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not two edges after setup");
  AST_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_REFUSE: assert property (psel && penable && pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address map");
  AST_MANUAL: assert property (sw_wr && !auto_reg |=> switch_state == $past(pwdata[7:0]))
    else $error("manual switch write not applied");
  AST_AUTO_IGNORE: assert property (sw_wr && auto_reg |=> $stable(switch_state))
    else $error("switch write changed switches in auto mode");
  AST_ANALOG_INV: assert property (ctl_wr |=> tip_analog_invert == $past(pwdata[2]))
    else $error("tip analog invert output wrong");
  AST_TRIM: assert property (ctl_wr |=> impedance_threshold_trim == $past(pwdata[11:8]))
    else $error("impedance trim output wrong");
  AST_PULLUP: assert property (ctl_wr |=> ring_pullup_sel == ($past(pwdata[5]) ? ($past(pwdata[6]) ? 2'h2 : 2'h1) : 2'h0))
    else $error("ring pull-up select wrong");
  AST_MIC_SHORT: assert property (!cfg_seen |-> !mic_short_enable)
    else $error("mic short enabled before configuration");
  COV_START: cover property (ctl_wr && pwdata[jack_pkg::start_bit]);
  COV_REFUSED: cover property (pready && pslverr);
  COV_CONFIGURED: cover property ($rose(mic_short_enable));
endmodule : jack_props
bind headset_type_and_plug_sense jack_props props_u (
  .mclk(mclk), .reset(reset), .standby_reset(standby_reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .switch_state(switch_state), .tip_analog_invert(tip_analog_invert),
  .ring_pullup_sel(ring_pullup_sel), .impedance_threshold_trim(impedance_threshold_trim),
  .mic_short_enable(mic_short_enable));
`default_nettype wire

// file: sim/tb_headset_type_and_plug_sense.sv
`timescale 1ns/1ps
`default_nettype none
module tb_headset_type_and_plug_sense;
  localparam int DB = 4;
  localparam int ST = 3;
  logic                  mclk, reset, standby_reset, psel, penable, pwrite, pready, pslverr;
  logic                  err, plugged, metal, tinv, rinv, tip, ring, c3, c4, imp, ainv, mse, irq;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [2:0]            htype;
  logic [1:0]            pu;
  logic [3:0]            trim;
  jack_pkg::switch_set_s sw;
  int                    miscompares, check_count, cyc, n;
  headset_type_and_plug_sense #(.DBNC_CYCLES(DB), .SETTLE_CYCLES(ST)) dut_u (
    .mclk(mclk), .reset(reset), .standby_reset(standby_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tip_sense_pin(tip), .ring_sense_pin(ring),
    .cmp_three_pin(c3), .cmp_four_pin(c4), .ring_imp_pin(imp), .switch_state(sw),
    .tip_analog_invert(ainv), .ring_pullup_sel(pu), .impedance_threshold_trim(trim),
    .mic_short_enable(mse), .irq(irq));
  plug_model plug_u (.plugged(plugged), .metal(metal), .tip_inv(tinv), .ring_inv(rinv),
    .htype(htype), .tip_pin(tip), .ring_pin(ring), .c3(c3), .c4(c4));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ==========================================================
  // bus and compare tasks
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // test sequence
  initial begin
    {reset, standby_reset} = 2'b11;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {plugged, metal, tinv, rinv, imp, htype} = '0;
    repeat (3) @(posedge mclk);
    reset         <= 1'b0;
    standby_reset <= 1'b0;
    @(posedge mclk);
    chk("mic short idle", 0, 32'(mse));
    apb(jack_pkg::ctrl_addr, 1'b0, 0);
    chk("ctrl reset", jack_pkg::ctrl_reset, rd);
    apb(8'h20, 1'b0, 0);
    chk("unmapped err", 1, 32'(err));
    for (int m = 0; m < 4; m++) begin
      apb(jack_pkg::ctrl_addr, 1'b1, 32'(m));
      apb(jack_pkg::switch_addr, 1'b1, 32'h3c);
      apb(jack_pkg::switch_addr, 1'b1, 32'(8'h30 + m));
      chk("manual switch", m < 2 ? 32'(8'h30 + m) : 32'h31, 32'(sw));
    end
    for (int t = 1; t < 5; t++) begin
      htype <= 3'(t);
      repeat (4) @(posedge mclk);
      apb(jack_pkg::ctrl_addr, 1'b1, 32'h82);
      n = 0;
      do begin
        apb(jack_pkg::irq_stat_addr, 1'b0, 0);
        n++;
      end while (rd[jack_pkg::irq_det_bit] !== 1'b1 && n < 40);
      htype <= 3'h0;
      apb(jack_pkg::irq_stat_addr, 1'b1, 32'h4);
      apb(jack_pkg::status_addr, 1'b0, 0);
      chk("type", 32'(t), 32'(rd[10:8]));
      // the detector applies the switch pattern for that type once the type is known
      chk("pattern", (t == 3) ? 32'hf3 : (t == 2) ? 32'h59 : 32'ha6, 32'(sw));
      chk("configured", 1, 32'(mse));
    end
    for (int k = 0; k < 4; k++) begin
      {tinv, rinv} <= {2{k[1]}};
      metal        <= ~k[0];
      plugged      <= 1'b0;
      apb(jack_pkg::ctrl_addr, 1'b1, k[1] ? 32'h14 : 32'h0);
      repeat (DB + 6) @(posedge mclk);
      apb(jack_pkg::irq_stat_addr, 1'b1, 32'h7);
      plugged <= 1'b1;
      @(posedge mclk);
      plugged <= 1'b0;
      repeat (DB + 6) @(posedge mclk);
      apb(jack_pkg::status_addr, 1'b0, 0);
      chk("glitch", 0, 32'(rd[12:11]));
      plugged <= 1'b1;
      repeat (DB + 6) @(posedge mclk);
      apb(jack_pkg::status_addr, 1'b0, 0);
      chk("tip present", 1, 32'(rd[11]));
      chk("ring present", 32'(k != 1), 32'(rd[12]));
      apb(jack_pkg::irq_stat_addr, 1'b0, 0);
      chk("change flags", {30'h0, k != 1, 1'b1}, rd & 32'h3);
      chk("irq level", 1, 32'(irq));
    end
    apb(jack_pkg::irq_mask_addr, 1'b1, 32'h7);
    chk("irq masked", 0, 32'(irq));
    apb(jack_pkg::irq_mask_addr, 1'b1, 32'h0);
    apb(jack_pkg::irq_stat_addr, 1'b1, 32'h7);
    chk("irq cleared", 0, 32'(irq));
    apb(jack_pkg::ctrl_addr, 1'b1, 32'h1c);
    apb(jack_pkg::status_addr, 1'b0, 0);
    chk("status invert", 32'h1000, rd & 32'h1800);
    chk("analog invert", 1, 32'(ainv));
    imp <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(jack_pkg::ctrl_addr, 1'b1, 32'(k * 32 + (k + 5) * 256));
      chk("pullup", k[0] ? (k[1] ? 2 : 1) : 0, 32'(pu));
      chk("trim", 32'(k + 5), 32'(trim));
    end
    apb(jack_pkg::status_addr, 1'b0, 0);
    chk("imp flag", 1, 32'(rd[14]));
    report_and_stop();
  end
endmodule : tb_headset_type_and_plug_sense
`default_nettype wire
